//--- rtl/lcc_cluster.sv
// Cluster of ten logic cells with control selection and APB configuration
`timescale 1ns/1ns
module lcc_cluster
(
  // APB clock and reset
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  // APB slave
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [lcc_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]                pwdata,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  // Dedicated global control pins
  input  wire logic [3:0]                 global_pin,
  // Local interconnect data, four per cell
  input  wire logic [39:0]                data_in,
  // Chain links from the cluster below
  input  wire logic                       carry_in,
  input  wire logic                       cascade_in,
  // Chain links to the cluster above
  output logic                            carry_out,
  output logic                            cascade_out,
  // Cell outputs to both local interconnects and row/column routing
  output logic      [9:0]                 local_a_out,
  output logic      [9:0]                 local_b_out,
  output logic      [9:0]                 route_out,
  // Global control lines as driven after source selection
  output logic      [3:0]                 global_out
);

  localparam int NC = lcc_pkg::N_CELLS;
  localparam int NG = lcc_pkg::N_GLOBAL;

  // ----------------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------------
  logic [31:0]   ctrl_reg;
  logic [31:0]   gsrc_reg;
  logic [31:0]   cell_cfg_reg [NC];
  logic [31:0]   rd_data;
  logic [31:0]   status_word;
  logic [NG-1:0] global_reg;
  logic [NG-1:0] global_next;
  logic [NG-1:0] pin_sync;
  logic          clk_prev_reg;

  // ----------------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------------
  logic                       setup_phase;
  logic                       access_phase;
  logic                       hit_ctrl;
  logic                       hit_gsrc;
  logic                       hit_cell;
  logic                       hit_status;
  logic                       mapped;
  logic [lcc_pkg::ADDR_W-1:0] cell_offs;
  logic [3:0]                 cell_idx;
  logic                       wr_en;

  // Decoding is combinational; no wait states are ever inserted
  assign setup_phase  = psel & ~penable;
  assign access_phase = psel & penable;
  assign hit_ctrl     = (paddr == lcc_pkg::CTRL_OFFSET);
  assign hit_gsrc     = (paddr == lcc_pkg::GSRC_OFFSET);
  assign hit_status   = (paddr == lcc_pkg::STATUS_OFFSET);
  assign cell_offs    = paddr - lcc_pkg::CELL_OFFSET;
  assign hit_cell     = (paddr >= lcc_pkg::CELL_OFFSET) && (paddr < lcc_pkg::STATUS_OFFSET)
                        && (paddr[1:0] == 2'h0);
  assign cell_idx     = cell_offs[5:2];
  assign mapped       = hit_ctrl | hit_gsrc | hit_cell | hit_status;
  assign wr_en        = access_phase & pwrite & mapped;
  assign pready       = 1'b1;
  assign pslverr      = access_phase & ~mapped;

  // Read selection; unmapped reads give zero
  assign rd_data = hit_ctrl   ? ctrl_reg :
                   hit_gsrc   ? gsrc_reg :
                   hit_cell   ? cell_cfg_reg[cell_idx] :
                   hit_status ? status_word : 32'h0000_0000;

  // Control and global source registers; status is read only
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_reg <= lcc_pkg::CTRL_RESET;
      gsrc_reg <= lcc_pkg::GSRC_RESET;
    end
    else if (wr_en)
    begin
      if (hit_ctrl)
        ctrl_reg <= pwdata;
      if (hit_gsrc)
        gsrc_reg <= pwdata;
    end
  end

  // Cell configuration words
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < NC; i++)
        cell_cfg_reg[i] <= lcc_pkg::CELL_RESET;
    end
    else if (wr_en && hit_cell)
      cell_cfg_reg[cell_idx] <= pwdata;
  end

  // Read data is captured in the setup cycle so it leaves a flip-flop
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (setup_phase && !pwrite)
      prdata <= rd_data;
  end

  // ----------------------------------------------------------------------
  // Global control lines
  // ----------------------------------------------------------------------
  logic [NC-1:0] cell_out;
  logic [NC-1:0] cell_q;

  // Pins cross from outside, so each passes the filtered synchroniser
  lcc_sync3
  #(
    .WIDTH (NG)
  )
  u_pin_sync
  (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (global_pin),
    .sync_out (pin_sync)
  );

  // Each line takes its pin or any cell output of this cluster
  always_comb
  begin
    logic [3:0] src_idx;
    src_idx     = 4'h0;
    global_next = pin_sync;
    for (int g = 0; g < NG; g++)
    begin
      src_idx = gsrc_reg[g*lcc_pkg::GSRC_FIELD_W +: 4];
      if (gsrc_reg[g*lcc_pkg::GSRC_FIELD_W + lcc_pkg::GSRC_SEL_BIT])
        global_next[g] = (src_idx < 4'(NC)) ? cell_out[src_idx] : 1'b0;
    end
  end

  // Registered so the dedicated lines leave the cluster glitch free
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      global_reg <= '0;
    else
      global_reg <= global_next;
  end

  assign global_out = global_reg;

  // ----------------------------------------------------------------------
  // Cluster control selection
  // ----------------------------------------------------------------------
  logic [1:0] clk_sel;
  logic [1:0] clr_sel;
  logic       clk_level;
  logic       clr_level;
  logic       tick;
  logic       aclr;
  logic       sclr;
  logic       sload;

  assign clk_sel = ctrl_reg[lcc_pkg::CTRL_CLK_SEL_LSB +: 2];
  assign clr_sel = ctrl_reg[lcc_pkg::CTRL_CLR_SEL_LSB +: 2];

  // Local control takes the first cell's inputs instead of a global line
  assign clk_level = ctrl_reg[lcc_pkg::CTRL_CLK_LOCAL] ? data_in[0]
                                                       : global_reg[clk_sel];
  assign clr_level = ctrl_reg[lcc_pkg::CTRL_CLR_LOCAL] ? data_in[1]
                                                       : global_reg[clr_sel];
  assign aclr  = ctrl_reg[lcc_pkg::CTRL_CLR_EN] & clr_level;
  assign sclr  = ctrl_reg[lcc_pkg::CTRL_SCLR_EN] & data_in[2];
  assign sload = ctrl_reg[lcc_pkg::CTRL_SLOAD_EN] & data_in[3];

  // The selected clock acts on its rising edge, seen once per edge
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      clk_prev_reg <= 1'b0;
    else
      clk_prev_reg <= clk_level;
  end

  assign tick = clk_level & ~clk_prev_reg;

  // ----------------------------------------------------------------------
  // Cells and chains
  // ----------------------------------------------------------------------
  logic [NC-1:0] carry_link;
  logic [NC-1:0] casc_link;
  logic [NC-1:0] carry_feed;
  logic [NC-1:0] casc_feed;

  // The first cell stays out of both chains; cell one takes the links below
  assign carry_feed[0] = 1'b0;
  assign casc_feed[0]  = 1'b1;
  assign carry_feed[1] = carry_in;
  assign casc_feed[1]  = cascade_in;
  assign carry_feed[NC-1:2] = carry_link[NC-2:1];
  assign casc_feed[NC-1:2]  = casc_link[NC-2:1];

  genvar k;
  generate
    for (k = 0; k < NC; k++)
    begin : g_cell
      lcc_cell u_cell
      (
        .pclk      (pclk),
        .presetn   (presetn),
        .table_cfg (cell_cfg_reg[k][lcc_pkg::CELL_TABLE_LSB +: 16]),
        .ff_mode   (cell_cfg_reg[k][lcc_pkg::CELL_MODE_LSB +: 2]),
        .bypass    (cell_cfg_reg[k][lcc_pkg::CELL_BYPASS]),
        .arith     (cell_cfg_reg[k][lcc_pkg::CELL_ARITH]),
        .carry_sel (cell_cfg_reg[k][lcc_pkg::CELL_CARRY_SEL]),
        .casc_en   (cell_cfg_reg[k][lcc_pkg::CELL_CASC_EN]),
        .casc_or   (cell_cfg_reg[k][lcc_pkg::CELL_CASC_OR]),
        .data      (data_in[k*lcc_pkg::N_INPUTS +: 4]),
        .carry_in  (carry_feed[k]),
        .casc_in   (casc_feed[k]),
        .tick      (tick),
        .aclr      (aclr),
        .sclr      (sclr),
        .sload     (sload),
        .cell_out  (cell_out[k]),
        .q_reg     (cell_q[k]),
        .carry_out (carry_link[k]),
        .casc_out  (casc_link[k])
      );
    end
  endgenerate

  // Chain ends continue into the next cluster of the row half
  assign carry_out   = carry_link[NC-1];
  assign cascade_out = casc_link[NC-1];

  // Same value on both local interconnects and the routing network
  assign local_a_out = cell_out;
  assign local_b_out = cell_out;
  assign route_out   = cell_out;

  // ----------------------------------------------------------------------
  // Status
  // ----------------------------------------------------------------------
  assign status_word = {6'h00, global_reg, casc_link[NC-1], carry_link[NC-1], cell_q, cell_out};

endmodule // lcc_cluster

//--- rtl/lcc_pkg.sv
// Constants shared by the logic cell cluster design files
package lcc_pkg;

  // ----------------------------------------------------------------------
  // Structure
  // ----------------------------------------------------------------------
  localparam int N_CELLS  = 10;
  localparam int N_GLOBAL = 4;
  localparam int N_INPUTS = 4;
  localparam int ADDR_W   = 12;

  // ----------------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [11:0] CTRL_OFFSET   = 12'h000;
  localparam logic [11:0] GSRC_OFFSET   = 12'h004;
  localparam logic [11:0] CELL_OFFSET   = 12'h008;
  localparam logic [11:0] STATUS_OFFSET = 12'h030;

  // ----------------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------------
  localparam int CTRL_CLK_SEL_LSB = 0;
  localparam int CTRL_CLK_LOCAL   = 2;
  localparam int CTRL_CLR_SEL_LSB = 3;
  localparam int CTRL_CLR_LOCAL   = 5;
  localparam int CTRL_CLR_EN      = 6;
  localparam int CTRL_SCLR_EN     = 7;
  localparam int CTRL_SLOAD_EN    = 8;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

  // Global source register: five bits per line, select then cell index
  localparam int GSRC_FIELD_W   = 5;
  localparam int GSRC_SEL_BIT   = 4;
  localparam logic [31:0] GSRC_RESET = 32'h0000_0000;

  // ----------------------------------------------------------------------
  // Cell configuration fields
  // ----------------------------------------------------------------------
  localparam int CELL_TABLE_LSB = 0;
  localparam int CELL_MODE_LSB  = 16;
  localparam int CELL_BYPASS    = 18;
  localparam int CELL_ARITH     = 19;
  localparam int CELL_CARRY_SEL = 20;
  localparam int CELL_CASC_EN   = 21;
  localparam int CELL_CASC_OR   = 22;
  localparam logic [31:0] CELL_RESET = 32'h0004_0000;

  // Flip-flop behaviour codes
  localparam logic [1:0] FF_D  = 2'h0;
  localparam logic [1:0] FF_T  = 2'h1;
  localparam logic [1:0] FF_JK = 2'h2;
  localparam logic [1:0] FF_SR = 2'h3;

  // ----------------------------------------------------------------------
  // Status register fields
  // ----------------------------------------------------------------------
  localparam int STAT_OUT_LSB    = 0;
  localparam int STAT_Q_LSB      = 10;
  localparam int STAT_CARRY      = 20;
  localparam int STAT_CASC       = 21;
  localparam int STAT_GLOBAL_LSB = 22;

endpackage

//--- rtl/lcc_sync3.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ns
module lcc_sync3
#(
  parameter int WIDTH = 4
)
(
  // Clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // Asynchronous input and filtered result
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] s1_reg;
  logic [WIDTH-1:0] s2_reg;
  logic [WIDTH-1:0] s3_reg;
  logic [WIDTH-1:0] agree;
  logic [WIDTH-1:0] stable_next;

  // Only stages two and three are compared; stage one may be metastable
  assign agree       = ~(s2_reg ^ s3_reg);
  assign stable_next = (agree & s2_reg) | (~agree & sync_out);

  // ----------------------------------------------------------------------
  // Shift chain and filtered value
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s1_reg   <= '0;
      s2_reg   <= '0;
      s3_reg   <= '0;
      sync_out <= '0;
    end
    else
    begin
      s1_reg   <= async_in;
      s2_reg   <= s1_reg;
      s3_reg   <= s2_reg;
      sync_out <= stable_next;
    end
  end

endmodule // lcc_sync3

//--- rtl/lcc_cell.sv
// One logic cell: function table, chains and configurable flip-flop
`timescale 1ns/1ns
module lcc_cell
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Configuration
  input  wire logic [15:0] table_cfg,
  input  wire logic [1:0]  ff_mode,
  input  wire logic        bypass,
  input  wire logic        arith,
  input  wire logic        carry_sel,
  input  wire logic        casc_en,
  input  wire logic        casc_or,
  // Data and chain inputs
  input  wire logic [3:0]  data,
  input  wire logic        carry_in,
  input  wire logic        casc_in,
  // Cluster-wide control
  input  wire logic        tick,
  input  wire logic        aclr,
  input  wire logic        sclr,
  input  wire logic        sload,
  // Results
  output logic             cell_out,
  output logic             q_reg,
  output logic             carry_out,
  output logic             casc_out
);

  logic [3:0] idx4;
  logic [3:0] idx_sum;
  logic [3:0] idx_cy;
  logic       f4;
  logic       f_sum;
  logic       f;
  logic       comb;
  logic       q_next;

  // Any four-input function by table lookup; carry may replace input three
  assign idx4    = {carry_sel ? carry_in : data[3], data[2:0]};
  assign f4      = table_cfg[idx4];
  // Arithmetic splits the table into sum and carry halves
  assign idx_sum = {1'b0, carry_in, data[1:0]};
  assign idx_cy  = {1'b1, carry_in, data[1:0]};
  assign f_sum   = table_cfg[idx_sum];
  assign f       = arith ? f_sum : f4;
  assign carry_out = arith ? table_cfg[idx_cy] : carry_in;
  // Cascade joins this table to the one before it
  assign comb     = casc_en ? (casc_or ? (f | casc_in) : (f & casc_in)) : f;
  assign casc_out = comb;

  // ----------------------------------------------------------------------
  // Flip-flop behaviour
  // ----------------------------------------------------------------------
  always_comb
  begin
    q_next = q_reg;
    case (ff_mode)
      lcc_pkg::FF_D:  q_next = comb;
      lcc_pkg::FF_T:  q_next = q_reg ^ comb;
      lcc_pkg::FF_JK:
      begin
        case ({comb, data[2]})
          2'h1:    q_next = 1'b0;
          2'h2:    q_next = 1'b1;
          2'h3:    q_next = ~q_reg;
          default: q_next = q_reg;
        endcase
      end
      lcc_pkg::FF_SR:
      begin
        // Set and reset together hold the state
        if (comb && !data[2])
          q_next = 1'b1;
        else if (!comb && data[2])
          q_next = 1'b0;
      end
      default: q_next = q_reg;
    endcase
  end

  // Clear wins over load, load over the configured behaviour
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      q_reg <= 1'b0;
    else if (aclr)
      q_reg <= 1'b0;
    else if (tick)
    begin
      if (sclr)
        q_reg <= 1'b0;
      else if (sload)
        q_reg <= data[1];
      else
        q_reg <= q_next;
    end
  end

  // Unless bypassed, clear masks the output at once, before the register itself falls
  assign cell_out = bypass ? comb : (q_reg & ~aclr);

endmodule // lcc_cell

//--- sim/lcc_asserts.sv
// Port-level assertions for the logic cell cluster
`timescale 1ns/1ns
module lcc_asserts
(
  // Clock and reset
  input wire logic                       pclk,
  input wire logic                       presetn,
  // Register bus
  input wire logic                       psel,
  input wire logic                       penable,
  input wire logic                       pwrite,
  input wire logic [lcc_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0]                prdata,
  input wire logic                       pready,
  input wire logic                       pslverr,
  // Fabric side
  input wire logic                       carry_in,
  input wire logic                       carry_out,
  input wire logic                       cascade_out,
  input wire logic [9:0]                 local_a_out,
  input wire logic [9:0]                 local_b_out,
  input wire logic [9:0]                 route_out,
  input wire logic [3:0]                 global_out
);
  // ----------------------------------------------------------------
  // Clocking and bus sequences
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // Read setup cycle; data is captured here, not in the access phase
  sequence setup_rd;
    psel && !penable && !pwrite;
  endsequence

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  ready_const_a: assert property (pready)
    else $error("ready dropped");
  err_idle_a: assert property (!(psel && penable) |-> !pslverr)
    else $error("error flag outside access");
  err_unmapped_a: assert property (psel && penable && paddr[1:0] == 2'h0
    |-> pslverr == (paddr > 12'h030)) else $error("error flag wrong");
  zero_unmapped_a: assert property (setup_rd ##0 (paddr > 12'h030)
    |=> prdata == 32'h0) else $error("unmapped read not zero");
  rdata_hold_a: assert property (!(psel && !penable && !pwrite)
    |=> $stable(prdata)) else $error("read data moved");
  status_mirror_a: assert property (
    setup_rd ##0 (paddr == 12'h030) |=> prdata[9:0] == $past(route_out)
    && prdata[21:20] == {$past(cascade_out), $past(carry_out)}
    && prdata[25:22] == $past(global_out)) else $error("status mismatch");
  outs_equal_a: assert property (
    local_a_out == route_out && local_b_out == route_out)
    else $error("cell output copies differ");
  reset_quiet_a: assert property (
    $rose(presetn) |-> route_out == 10'h0 && global_out == 4'h0
    && carry_out == carry_in && !cascade_out) else $error("bad reset state");
endmodule // lcc_asserts

//--- sim/lcc_fabric.sv
// Neighbouring fabric model that drives the cluster's data and pins
`timescale 1ns/1ns
module lcc_fabric
(
  // Clock
  input wire logic  pclk,
  // Drive toward the cluster
  output logic [39:0] data_in,
  output logic        carry_in,
  output logic        cascade_in,
  output logic [3:0]  global_pin
);
  // Quiet fabric at time zero
  initial
  begin
    data_in    = 40'h0;
    carry_in   = 1'b0;
    cascade_in = 1'b0;
    global_pin = 4'h0;
  end

  // New routing values land just after an edge, like a real neighbour
  task automatic drive(input logic [39:0] d);
    @(posedge pclk);
    data_in <= d;
  endtask

  // Chain links from the cluster below
  task automatic chain(input logic c, input logic s);
    @(posedge pclk);
    carry_in   <= c;
    cascade_in <= s;
  endtask

  // Dedicated global control pins
  task automatic pins(input logic [3:0] g);
    @(posedge pclk);
    global_pin <= g;
  endtask
endmodule // lcc_fabric

//--- sim/lcc_cluster_tb.sv
// Self-checking bench for the logic cell cluster
`timescale 1ns/1ns
module lcc_cluster_tb;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [39:0] data_in;
  logic [3:0]  global_pin, global_out;
  logic        carry_in, cascade_in, carry_out, cascade_out;
  logic [9:0]  local_a_out, local_b_out, route_out;
  int          n_errors = 0;
  int          checks = 0;
  // Mode, nibble, expected q for every flip-flop behaviour
  logic [6:0]  steps [13] = '{7'h03, 7'h00, 7'h23, 7'h22, 7'h20, 7'h43,
    7'h48, 7'h4b, 7'h41, 7'h68, 7'h63, 7'h6b, 7'h61};

  lcc_cluster i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .global_pin, .data_in, .carry_in,
    .cascade_in, .carry_out, .cascade_out, .local_a_out, .local_b_out,
    .route_out, .global_out);
  lcc_fabric i_fab (.pclk, .data_in, .carry_in, .cascade_in, .global_pin);

  // Free-running 100 MHz clock
  always #5 pclk = ~pclk;

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic finish_test;
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One APB transfer; an idle edge follows so strobes never double up
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] r, output logic e);
    int n;
    n = 0;
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1 && ++n < 50);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    if (n == 50)
    begin
      chk(32'h0, 32'h1);
      finish_test;
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, x);
    chk(32'(e), 32'(xe));
  endtask

  // Same configuration into cells one to nine
  task automatic cfg(input logic [31:0] v);
    for (int k = 1; k < 10; k++)
      wr(lcc_pkg::CELL_OFFSET + 12'(4 * k), v);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge pclk);
    @(negedge pclk);
  endtask

  // Local clock low then high on cell zero input zero; ctl drives inputs 3..1
  task automatic pulse(input logic [2:0] ctl, input logic [3:0] nib);
    i_fab.drive({{9{nib}}, ctl, 1'b0});
    i_fab.drive({{9{nib}}, ctl, 1'b1});
    settle(4);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs;
    rd(lcc_pkg::CTRL_OFFSET, 32'h0, 1'b0);
    rd(lcc_pkg::GSRC_OFFSET, 32'h0, 1'b0);
    for (int k = 0; k < 10; k++)
      rd(lcc_pkg::CELL_OFFSET + 12'(4 * k), 32'h0004_0000, 1'b0);
    wr(lcc_pkg::STATUS_OFFSET, 32'hffff_ffff);
    wr(12'h034, 32'hffff_ffff);
    rd(lcc_pkg::STATUS_OFFSET, 32'h0, 1'b0);
    rd(12'h034, 32'h0, 1'b1);
  endtask

  // Parity table on every cell, all sixteen input codes
  task automatic t_table;
    for (int k = 0; k < 10; k++)
      wr(lcc_pkg::CELL_OFFSET + 12'(4 * k), 32'h0004_6996);
    for (int i = 0; i < 16; i++)
    begin
      i_fab.drive({10{4'(i)}});
      settle(1);
      chk(32'(route_out), {22'h0, {10{^4'(i)}}});
      chk(32'(local_a_out), {22'h0, {10{^4'(i)}}});
    end
  endtask

  // D, T, JK and SR behaviour on the local clock
  task automatic t_modes;
    wr(lcc_pkg::CTRL_OFFSET, 32'h0000_0004);
    foreach (steps[i])
    begin
      cfg({14'h0, steps[i][6:5], 16'haaaa});
      pulse(3'b000, steps[i][4:1]);
      chk(32'(route_out[9:1]), {23'h0, {9{steps[i][0]}}});
    end
  endtask

  // Local async clear, sync clear and sync load on the registers of cells one to nine
  task automatic t_ctrl;
    wr(lcc_pkg::CTRL_OFFSET, 32'h0000_01e4);
    cfg(32'h0000_aaaa);
    i_fab.drive({{9{4'h1}}, 3'b001, 1'b1});
    settle(1);
    chk(32'(route_out[9:1]), 32'h0);
    i_fab.drive({{9{4'h1}}, 3'b000, 1'b1});
    pulse(3'b000, 4'h1);
    chk(32'(route_out[9:1]), 32'h1ff);
    pulse(3'b010, 4'h1);
    chk(32'(route_out[9:1]), 32'h0);
    pulse(3'b100, 4'h2);
    chk(32'(route_out[9:1]), 32'h1ff);
    pulse(3'b110, 4'h2);
    chk(32'(route_out[9:1]), 32'h0);
  endtask

  // Nine-bit adder on the carry path, then cascade AND and OR
  task automatic t_chain;
    logic [8:0]  a [3] = '{9'h1ff, 9'h155, 9'h0f0};
    logic [8:0]  b [3] = '{9'h001, 9'h0aa, 9'h10f};
    logic [9:0]  s;
    logic [39:0] d;
    wr(lcc_pkg::CTRL_OFFSET, 32'h0);
    cfg(32'h000c_e896);
    for (int v = 0; v < 3; v++)
    begin
      d = 40'h0;
      for (int k = 1; k < 10; k++)
        d[4 * k +: 4] = {2'b00, b[v][k - 1], a[v][k - 1]};
      i_fab.chain(v[0], 1'b0);
      i_fab.drive(d);
      settle(1);
      s = 10'(a[v]) + 10'(b[v]) + 10'(v[0]);
      chk(32'(route_out[9:1]), 32'(s[8:0]));
      chk(32'(carry_out), 32'(s[9]));
    end
    for (int m = 0; m < 2; m++)
    begin
      cfg(m ? 32'h0064_0000 : 32'h0024_ffff);
      for (int c = 0; c < 2; c++)
      begin
        i_fab.chain(c[0], c[0]);
        settle(1);
        chk(32'(cascade_out), 32'(c));
        chk(32'(carry_out), 32'(c));
      end
    end
    // Carry replaces table input three; the table passes that input straight out
    cfg(32'h0014_ff00);
    for (int c = 0; c < 2; c++)
    begin
      i_fab.chain(c[0], 1'b0);
      settle(1);
      chk(32'(route_out[9:1]), c ? 32'h1ff : 32'h0);
    end
  endtask

  // Clock from a global pin, then a global line fed by cell three
  task automatic t_global;
    int n;
    cfg(32'h0000_aaaa);
    i_fab.drive({{9{4'h1}}, 4'h0});
    i_fab.pins(4'h1);
    for (n = 0; n < 20 && route_out[9:1] !== 9'h1ff; n++)
      @(negedge pclk);
    chk(32'(route_out[9:1]), 32'h1ff);
    chk(32'(global_out), 32'h1);
    if (n == 20)
      finish_test;
    wr(lcc_pkg::GSRC_OFFSET, 32'h0000_0013);
    i_fab.pins(4'h0);
    settle(10);
    chk(32'(global_out), 32'h1);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    pclk    = 1'b0;
    presetn = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs;
    t_table;
    t_modes;
    t_ctrl;
    t_chain;
    t_global;
    finish_test;
  end
endmodule // lcc_cluster_tb

bind lcc_cluster lcc_asserts i_chk (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .prdata, .pready, .pslverr, .carry_in, .carry_out, .cascade_out,
  .local_a_out, .local_b_out, .route_out, .global_out);
